/* File: sls_defines.svh */
`ifndef SLS_DEFINES_SVH
`define SLS_DEFINES_SVH

// Register indices; byte address is four times the index
`define SLS_IDX_BAD_CTRL     12'h46f
`define SLS_IDX_GROUP_LOCK   12'h470
`define SLS_IDX_FRAME_LOCK   12'h471
`define SLS_IDX_LINK_PAGE    12'h300
`define SLS_IDX_THRESHOLD    12'h301
`define SLS_IDX_IRQ_STATUS   12'h302
`define SLS_IDX_IRQ_MASK     12'h303

// Width of the byte address and of the word offset inside it
`define SLS_ADDR_W           14
`define SLS_BYTE_OFS_W       2

// Reset values of writable registers
`define SLS_THRESH_RESET     8'hff
`define SLS_MASK_RESET       32'h0000_0000
`define SLS_PAGE_RESET       1'h0

// Event positions inside one link's group of interrupt bits
`define SLS_EV_BAD_CTRL      0
`define SLS_EV_GROUP_LOST    1
`define SLS_EV_FRAME_LOST    2
`define SLS_EV_PER_LINK      3

`endif

/* File: sls_pkg.sv */
`default_nettype none

package sls_pkg;

    // Bus phase tracker, one-hot
    typedef enum logic [1:0] {
        SLS_ST_IDLE   = 2'b01,
        SLS_ST_ACCESS = 2'b10
    } sls_apb_state_type;

    // Threshold and error count width
    typedef logic [7:0] sls_count_type;

    // Bus data word
    typedef logic [31:0] sls_word_type;

endpackage : sls_pkg

`default_nettype wire

/* File: sls_sticky_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module sls_sticky_flags #(
    parameter int W = 6
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set_pulse,
    input  wire logic [W-1:0] clear_bits,
    output logic      [W-1:0] flags_reg
);

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~clear_bits) | set_pulse;
        end
    end

endmodule : sls_sticky_flags

`default_nettype wire

/* File: sls_link_status.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sls_defines.svh"

module sls_link_status #(
    parameter int LANES = 8,
    parameter int CNT_W = 8
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [CNT_W-1:0]       error_threshold,
    input  wire logic [LANES*CNT_W-1:0] lane_err_count,
    input  wire logic [LANES-1:0]       group_lock_in,
    input  wire logic [LANES-1:0]       frame_lock_in,
    output logic      [LANES-1:0]       bad_ctrl_char_reg,
    output logic      [LANES-1:0]       group_lock_reg,
    output logic      [LANES-1:0]       frame_lock_reg,
    output logic      [2:0]             event_reg
);

    logic [LANES-1:0] over_thr;

    ////////////////////////////////////////////////////////////////////////
    // Per-lane threshold compare, bit n is lane n
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign over_thr[i] = lane_err_count[i*CNT_W +: CNT_W] >= error_threshold;

        property p_thresh_cmp;
            @(posedge pclk) disable iff (!presetn)
            1'b1 |=> bad_ctrl_char_reg[i] ==
                ($past(lane_err_count[i*CNT_W +: CNT_W]) >= $past(error_threshold));
        endproperty
        a_thresh_cmp: assert property (p_thresh_cmp)
            else $error("control char status does not follow threshold compare");
    end

    ////////////////////////////////////////////////////////////////////////
    // Status snapshot; zero from reset, no software path
    // read-only, reset zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_ctrl_char_reg <= '0;
            group_lock_reg    <= '0;
            frame_lock_reg    <= '0;
        end else begin
            bad_ctrl_char_reg <= over_thr;
            group_lock_reg    <= group_lock_in;
            frame_lock_reg    <= frame_lock_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events: threshold newly reached, lock newly lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_reg <= '0;
        end else begin
            event_reg[`SLS_EV_BAD_CTRL]   <= |(over_thr & ~bad_ctrl_char_reg);
            event_reg[`SLS_EV_GROUP_LOST] <= |(group_lock_reg & ~group_lock_in);
            event_reg[`SLS_EV_FRAME_LOST] <= |(frame_lock_reg & ~frame_lock_in);
        end
    end

endmodule : sls_link_status

`default_nettype wire

/* File: sls_lane_status.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sls_defines.svh"

//Contract
// - Control char bit is 1 when lane error count reaches the threshold.
// - Control char status bit n belongs to lane n, from bit zero.
// - Code-group lock register holds lanes 0 to 7, one for lock.
// - Frame lock register holds one bit per lane, one for lock.
// - Control char, code-group lock and frame lock reads return the link chosen by the page register.
// - Lock bits read 0 when lost and 1 when achieved.
module sls_lane_status #(
    parameter int NUM_LINKS = 2,
    parameter int LANES     = 8,
    parameter int CNT_W     = 8
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [`SLS_ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [NUM_LINKS*LANES*CNT_W-1:0] lane_err_count,
    input  wire logic [NUM_LINKS*LANES-1:0]       group_lock_in,
    input  wire logic [NUM_LINKS*LANES-1:0]       frame_lock_in,
    output logic                                  irq
);

    import sls_pkg::*;

    localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
    localparam int EV_W   = `SLS_EV_PER_LINK * NUM_LINKS;

    // Byte addresses of the registers
    localparam logic [`SLS_ADDR_W-1:0] A_BAD_CTRL   = {`SLS_IDX_BAD_CTRL,   2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_GROUP_LOCK = {`SLS_IDX_GROUP_LOCK, 2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_FRAME_LOCK = {`SLS_IDX_FRAME_LOCK, 2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_LINK_PAGE  = {`SLS_IDX_LINK_PAGE,  2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_THRESHOLD  = {`SLS_IDX_THRESHOLD,  2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_IRQ_STATUS = {`SLS_IDX_IRQ_STATUS, 2'h0};
    localparam logic [`SLS_ADDR_W-1:0] A_IRQ_MASK   = {`SLS_IDX_IRQ_MASK,   2'h0};

    sls_apb_state_type state_reg;
    sls_apb_state_type state_next;
    logic [PAGE_W-1:0] link_page_reg;
    logic [CNT_W-1:0]  error_threshold_reg;
    logic [EV_W-1:0]   irq_mask_reg;
    logic [EV_W-1:0]   irq_status_reg;
    logic [EV_W-1:0]   event_set;
    logic [EV_W-1:0]   status_clear;
    logic [31:0]       prdata_reg;
    logic [31:0]       prdata_next;
    logic              miss_reg;
    logic              miss_next;
    logic              setup_phase;
    logic              access_done;
    logic              wr_done;
    logic              rd_done;
    logic [LANES-1:0]  bad_ctrl_all   [NUM_LINKS];
    logic [LANES-1:0]  group_lock_all [NUM_LINKS];
    logic [LANES-1:0]  frame_lock_all [NUM_LINKS];
    logic [LANES-1:0]  bad_ctrl_sel;
    logic [LANES-1:0]  group_lock_sel;
    logic [LANES-1:0]  frame_lock_sel;

    ////////////////////////////////////////////////////////////////////////
    // One status block per link
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
        sls_link_status #(
            .LANES (LANES),
            .CNT_W (CNT_W)
        ) u_link (
            .pclk              (pclk),
            .presetn           (presetn),
            .error_threshold   (error_threshold_reg),
            .lane_err_count    (lane_err_count[l*LANES*CNT_W +: LANES*CNT_W]),
            .group_lock_in     (group_lock_in[l*LANES +: LANES]),
            .frame_lock_in     (frame_lock_in[l*LANES +: LANES]),
            .bad_ctrl_char_reg (bad_ctrl_all[l]),
            .group_lock_reg    (group_lock_all[l]),
            .frame_lock_reg    (frame_lock_all[l]),
            .event_reg         (event_set[l*`SLS_EV_PER_LINK +: `SLS_EV_PER_LINK])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Paged view of the status registers
    // select by link page
    assign bad_ctrl_sel   = bad_ctrl_all[link_page_reg];
    assign group_lock_sel = group_lock_all[link_page_reg];
    assign frame_lock_sel = frame_lock_all[link_page_reg];

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking; one access cycle, no wait states
    assign setup_phase = psel && !penable;
    assign access_done = (state_reg == SLS_ST_ACCESS) && psel && penable;
    assign wr_done     = access_done && pwrite && !miss_reg;
    assign rd_done     = access_done && !pwrite && !miss_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SLS_ST_IDLE: begin
                if (setup_phase) begin
                    state_next = SLS_ST_ACCESS;
                end
            end
            SLS_ST_ACCESS: begin
                if (access_done || !psel) begin
                    state_next = SLS_ST_IDLE;
                end
            end
            default: begin
                state_next = SLS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SLS_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode, sampled in the setup cycle
    always_comb begin
        prdata_next = '0;
        miss_next   = 1'b0;
        unique case (paddr)
            A_BAD_CTRL:   prdata_next[LANES-1:0]  = bad_ctrl_sel;
            A_GROUP_LOCK: prdata_next[LANES-1:0]  = group_lock_sel;
            A_FRAME_LOCK: prdata_next[LANES-1:0]  = frame_lock_sel;
            A_LINK_PAGE:  prdata_next[PAGE_W-1:0] = link_page_reg;
            A_THRESHOLD:  prdata_next[CNT_W-1:0]  = error_threshold_reg;
            A_IRQ_STATUS: prdata_next[EV_W-1:0]   = irq_status_reg;
            A_IRQ_MASK:   prdata_next[EV_W-1:0]   = irq_mask_reg;
            default:      miss_next               = 1'b1;
        endcase
    end

    // Read data and decode result held through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            miss_reg   <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
            miss_reg   <= miss_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = (state_reg == SLS_ST_ACCESS);
    assign pslverr = pready && miss_reg;

    ////////////////////////////////////////////////////////////////////////
    // Writable control registers; status words take no write
    // writes to status ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_page_reg       <= PAGE_W'(`SLS_PAGE_RESET);
            error_threshold_reg <= CNT_W'(`SLS_THRESH_RESET);
            irq_mask_reg        <= EV_W'(`SLS_MASK_RESET);
        end else if (wr_done) begin
            if (paddr == A_LINK_PAGE) begin
                link_page_reg <= pwdata[PAGE_W-1:0];
            end
            if (paddr == A_THRESHOLD) begin
                error_threshold_reg <= pwdata[CNT_W-1:0];
            end
            if (paddr == A_IRQ_MASK) begin
                irq_mask_reg <= pwdata[EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status; a read clears only the bits it returned
    assign status_clear = (rd_done && paddr == A_IRQ_STATUS) ? prdata_reg[EV_W-1:0] : '0;

    sls_sticky_flags #(
        .W (EV_W)
    ) u_irq_flags (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_pulse  (event_set),
        .clear_bits (status_clear),
        .flags_reg  (irq_status_reg)
    );

    // Level interrupt while an unmasked bit is set
    assign irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_bad_ctrl_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == A_BAD_CTRL)
            |=> prdata[LANES-1:0] == $past(bad_ctrl_sel) && prdata[31:LANES] == '0;
    endproperty
    a_bad_ctrl_read: assert property (p_bad_ctrl_read)
        else $error("control char status read does not match lanes");

    property p_group_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == A_GROUP_LOCK)
            |=> pready && prdata[LANES-1:0] == $past(group_lock_sel);
    endproperty
    a_group_read: assert property (p_group_read)
        else $error("code-group lock read wrong");

    property p_frame_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == A_FRAME_LOCK)
            |=> pready && !pslverr && prdata[LANES-1:0] == $past(frame_lock_sel);
    endproperty
    a_frame_read: assert property (p_frame_read)
        else $error("frame lock read wrong");

    property p_page_one;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && paddr == A_GROUP_LOCK && link_page_reg == PAGE_W'(1))
            |=> prdata[LANES-1:0] == $past(group_lock_in[LANES +: LANES], 2);
    endproperty
    a_page_one: assert property (p_page_one)
        else $error("paged read does not show link one");

    sequence s_lane0_lost;
        $fell(group_lock_in[0]) && group_lock_all[0][0];
    endsequence

    sequence s_lane0_reported;
        !group_lock_all[0][0] ##1 irq_status_reg[`SLS_EV_GROUP_LOST];
    endsequence

    property p_lock_lost;
        @(posedge pclk) disable iff (!presetn)
        s_lane0_lost |=> s_lane0_reported;
    endproperty
    a_lock_lost: assert property (p_lock_lost)
        else $error("lost lock not reported as zero with event");

    property p_status_ro;
        @(posedge pclk) disable iff (!presetn)
        (access_done && pwrite && (paddr == A_GROUP_LOCK || paddr == A_FRAME_LOCK))
            |-> !pslverr ##1 group_lock_all[0] == $past(group_lock_in[LANES-1:0])
                && frame_lock_all[0] == $past(frame_lock_in[LANES-1:0]);
    endproperty
    a_status_ro: assert property (p_status_ro)
        else $error("status register disturbed by a write");

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == A_IRQ_STATUS && prdata[0] && !event_set[0])
            |=> !irq_status_reg[0] && !(irq && irq_status_reg == '0);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("interrupt status bit not cleared by read");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr == A_BAD_CTRL + `SLS_ADDR_W'(16)) |=> pready && pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not answered with error");

    // One answer cycle, then the slave is idle again
    sequence s_one_access;
        pready ##1 !pready;
    endsequence

    // Zero wait states: setup is always followed by exactly one ready cycle
    property p_ready_timing;
        @(posedge pclk) disable iff (!presetn)
        setup_phase |=> s_one_access;
    endproperty
    a_ready_timing: assert property (p_ready_timing)
        else $error("bus answer not exactly one cycle after setup");

    // Every event lands in its sticky bit, even against a clearing read
    property p_event_sticky;
        @(posedge pclk) disable iff (!presetn)
        |event_set |=> (irq_status_reg & $past(event_set)) == $past(event_set);
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("event lost instead of setting its status bit");

    property p_thresh_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && paddr == A_THRESHOLD) |=> error_threshold_reg == $past(pwdata[CNT_W-1:0]);
    endproperty
    a_thresh_write: assert property (p_thresh_write)
        else $error("threshold write did not take effect");

endmodule : sls_lane_status

`default_nettype wire

/* File: sls_lane_source.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-side lane model: error counts and lock flags per lane
module sls_lane_source #(
    parameter int N = 16
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           load,
    input  wire logic [N*8-1:0] count_in,
    input  wire logic [N-1:0]   group_in,
    input  wire logic [N-1:0]   frame_in,
    output logic      [N*8-1:0] lane_err_count,
    output logic      [N-1:0]   group_lock_in,
    output logic      [N-1:0]   frame_lock_in
);
    // Lane conditions change only on a load request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_err_count <= '0;
            group_lock_in  <= '0;
            frame_lock_in  <= '0;
        end else if (load) begin
            lane_err_count <= count_in;
            group_lock_in  <= group_in;
            frame_lock_in  <= frame_in;
        end
    end
endmodule : sls_lane_source

`default_nettype wire

/* File: serial_lane_sync_status_test.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sls_defines.svh"

module serial_lane_sync_status_test;
    localparam logic [13:0] A_BAD  = 14'(`SLS_IDX_BAD_CTRL * 4);
    localparam logic [13:0] A_GRP  = 14'(`SLS_IDX_GROUP_LOCK * 4);
    localparam logic [13:0] A_FRM  = 14'(`SLS_IDX_FRAME_LOCK * 4);
    localparam logic [13:0] A_PAGE = 14'(`SLS_IDX_LINK_PAGE * 4);
    localparam logic [13:0] A_THR  = 14'(`SLS_IDX_THRESHOLD * 4);
    localparam logic [13:0] A_IRQ  = 14'(`SLS_IDX_IRQ_STATUS * 4);
    localparam logic [13:0] A_MASK = 14'(`SLS_IDX_IRQ_MASK * 4);

    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, src_ld;
    logic [13:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [127:0] lane_err_count, cnt_v;
    logic [15:0]  group_lock_in, frame_lock_in, grp_v, frm_v;
    logic [7:0]   thr, c;
    logic         er;
    int           bad_count, checks_done, seed, it, i, pg;

    sls_lane_status DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lane_err_count(lane_err_count), .group_lock_in(group_lock_in),
        .frame_lock_in(frame_lock_in), .irq(irq));

    sls_lane_source src (.pclk(pclk), .presetn(presetn), .load(src_ld), .count_in(cnt_v),
        .group_in(grp_v), .frame_in(frm_v), .lane_err_count(lane_err_count),
        .group_lock_in(group_lock_in), .frame_lock_in(frame_lock_in));

    // Clock, 10 ns period
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
        check("slverr", 32'h0, {31'h0, er});
    endtask : rd_chk

    // Hand new lane conditions to the far side and let them settle
    task automatic load_lanes;
        @(posedge pclk);
        src_ld <= 1'b1;
        @(posedge pclk);
        src_ld <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : load_lanes

    function automatic logic [31:0] exp_bad(input int p, input logic [7:0] t);
        logic [31:0] r;
        r = '0;
        for (int n = 0; n < 8; n++) begin
            r[n] = (cnt_v[(p*8+n)*8 +: 8] >= t);
        end
        return r;
    endfunction : exp_bad

    initial begin
        seed = 32'h0e3c5de4;
        bad_count = 0;
        checks_done = 0;
        {psel, penable, pwrite, src_ld} = '0;
        paddr = '0;
        pwdata = '0;
        cnt_v = '0;
        grp_v = '0;
        frm_v = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_BAD, 32'h0, "bad_reset");
        rd_chk(A_GRP, 32'h0, "group_reset");
        rd_chk(A_FRM, 32'h0, "frame_reset");
        rd_chk(A_THR, 32'hff, "thr_reset");
        rd_chk(A_MASK, 32'h0, "mask_reset");
        for (it = 0; it < 40; it++) begin
            thr = 8'($random(seed));
            if (it == 1) thr = 8'h00;
            if (it == 2) thr = 8'hff;
            for (i = 0; i < 16; i++) begin
                c = 8'($random(seed));
                if (i % 4 == 1) c = thr;
                if (i % 4 == 2) c = thr - 8'h01;
                cnt_v[i*8 +: 8] = c;
            end
            grp_v = 16'($random(seed));
            frm_v = 16'($random(seed));
            load_lanes();
            apb(1'b1, A_THR, {24'h0, thr});
            if (it % 8 == 3) begin
                apb(1'b1, A_BAD, 32'hffffffff);
                apb(1'b1, A_GRP, 32'hffffffff);
                apb(1'b1, A_FRM, 32'hffffffff);
            end
            for (pg = 0; pg < 2; pg++) begin
                apb(1'b1, A_PAGE, 32'(pg));
                rd_chk(A_BAD, exp_bad(pg, thr), "bad_ctrl");
                rd_chk(A_GRP, {24'h0, grp_v[pg*8 +: 8]}, "group_lock");
                rd_chk(A_FRM, {24'h0, frm_v[pg*8 +: 8]}, "frame_lock");
            end
        end
        // Unmapped address refused
        apb(1'b0, A_BAD + 14'h0010, 32'h0);
        check("unmapped_err", 32'h1, {31'h0, er});
        check("unmapped_data", 32'h0, rd);
        // Interrupt raise, clear, mask
        grp_v = '1;
        frm_v = '1;
        load_lanes();
        apb(1'b1, A_MASK, 32'h3f);
        apb(1'b0, A_IRQ, 32'h0);
        @(posedge pclk);
        check("irq_clear", 32'h0, {31'h0, irq});
        grp_v[0] = 1'b0;
        load_lanes();
        check("irq_raise", 32'h1, {31'h0, irq});
        rd_chk(A_IRQ, 32'h2, "irq_status");
        @(posedge pclk);
        check("irq_read_clear", 32'h0, {31'h0, irq});
        apb(1'b1, A_MASK, 32'h0);
        frm_v[8] = 1'b0;
        load_lanes();
        check("irq_masked", 32'h0, {31'h0, irq});
        rd_chk(A_IRQ, 32'h20, "irq_masked_status");
        // Second reset in mid-run: status, page and threshold back to reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check("irq_reset", 32'h0, {31'h0, irq});
        rd_chk(A_IRQ, 32'h0, "irq_status_reset");
        rd_chk(A_PAGE, 32'h0, "page_reset");
        rd_chk(A_THR, 32'hff, "thr_reset2");
        rd_chk(A_GRP, 32'h0, "group_reset2");
        final_report();
    end
endmodule : serial_lane_sync_status_test

`default_nettype wire
